// >>> logic/eepr_pkg.sv
// Behaviour
// - Read frame opens with start, address, direction one
// - Current, random and sequential reads supported
// - Counter holds last accessed address plus one
// - Counter kept across frames, starts and stops
// - Read counter wraps across whole array
// - Current read sends counter byte, MSB first
// - Master ends single read with no-ack, stop
// - Random read opens with dummy address write
// - Master repeats start, sends read address
// - Device sends byte at freshly loaded address
// - Sequential read continues while master acknowledges
// - Master ack increments counter, next byte sent
// - Past top address counter wraps to zero
// - No-ack plus stop ends read, line released
// - Address byte is 1010, chip select, direction
// - Device acknowledges each byte it receives in a matched frame on ninth clock
// - Word address sent as two bytes, high first
// - Unmatched address gets no ack, device idles
package eepr_pkg;

    localparam int CORE_PERIOD_NS = 25;
    localparam int SCL_PERIOD_NS = 1000;
    // Quarter of a link clock period, rounded down
    localparam int SCL_QTR_CYC_I = (SCL_PERIOD_NS / 4) / CORE_PERIOD_NS;
    localparam logic [5:0] SCL_QTR_CYC = 6'((SCL_QTR_CYC_I < 1) ? 1 : SCL_QTR_CYC_I);

    localparam int ADDR_W = 15;
    localparam int MEM_DEPTH = 32768;
    localparam logic [3:0] DEV_PREFIX = 4'ha;
    localparam logic [2:0] LAST_BIT = 3'h7;
    localparam logic [3:0] ACK_BIT = 4'h8;
    localparam logic [ADDR_W-1:0] ADDR_RESET = 15'h0000;

    // Idle clocks sent after reset to flush the device
    localparam int RECOVER_BITS = 9;
    // Device link reset held for the first half of the recovery clocks
    localparam logic [8:0] DEV_RST_HOLD_CYC = 9'((RECOVER_BITS * 4 * SCL_QTR_CYC_I) / 2);

    typedef enum logic [2:0] {
        EEPR_DS_IDLE = 3'h0,
        EEPR_DS_RX = 3'h1,
        EEPR_DS_RX_ACK = 3'h3,
        EEPR_DS_TX = 3'h2,
        EEPR_DS_TX_ACK = 3'h6
    } eepr_dev_state_t;

    typedef enum logic [2:0] {
        EEPR_MS_REC = 3'h0,
        EEPR_MS_IDLE = 3'h1,
        EEPR_MS_START = 3'h3,
        EEPR_MS_BYTE = 3'h2,
        EEPR_MS_STOP = 3'h6
    } eepr_mst_state_t;

    typedef enum logic [2:0] {
        EEPR_ST_ADDR_WR = 3'h0,
        EEPR_ST_WADDR_HI = 3'h1,
        EEPR_ST_WADDR_LO = 3'h2,
        EEPR_ST_ADDR_RD = 3'h3,
        EEPR_ST_READ = 3'h4,
        EEPR_ST_RECOVER = 3'h5
    } eepr_step_t;

endpackage

// >>> logic/eepr_link_if.sv
`timescale 1ns/1ps
interface eepr_link_if;
    logic scl;
    logic m_sda_o;
    logic m_sda_oe;
    logic d_sda_o;
    logic d_sda_oe;
    logic sda;

    // Pulled-up open-drain data line
    assign sda = !((m_sda_oe && !m_sda_o) || (d_sda_oe && !d_sda_o));

    modport master (
        output scl,
        output m_sda_o,
        output m_sda_oe,
        input sda
    );

    modport eeprom (
        input scl,
        output d_sda_o,
        output d_sda_oe,
        input sda
    );
endinterface // eepr_link_if

// >>> logic/eepr_device.sv
`timescale 1ns/1ps
module eepr_device
(
    eepr_link_if.eeprom link,
    input wire logic core_clk,
    input wire logic reset,
    input wire logic chip_select_bit0,
    input wire logic chip_select_bit1,
    input wire logic chip_select_bit2,
    input wire logic load_en,
    input wire logic [eepr_pkg::ADDR_W-1:0] load_addr,
    input wire logic [7:0] load_data
);
    import eepr_pkg::*;

    logic [7:0] mem [0:MEM_DEPTH-1];
    logic [8:0] hold_reg;
    logic [8:0] hold_next;
    logic hold_act_reg;

    logic sda_pos_reg;
    logic rst_meta_reg;
    logic rst_sync_reg;
    logic [2:0] cs_meta_reg;
    logic [2:0] cs_sync_reg;

    eepr_dev_state_t state_reg;
    eepr_dev_state_t state_next;
    logic [2:0] cnt_reg;
    logic [2:0] cnt_next;
    logic [1:0] idx_reg;
    logic [1:0] idx_next;
    logic [7:0] shift_reg;
    logic [7:0] shift_next;
    logic [7:0] hi_reg;
    logic [7:0] hi_next;
    logic [ADDR_W-1:0] addr_reg;
    logic [ADDR_W-1:0] addr_next;
    logic rw_reg;
    logic rw_next;
    logic oe_reg;
    logic oe_next;

    logic [7:0] rx_byte;
    logic [7:0] tx_byte;
    logic start_seen;

    // Preload port; writes over the link are not stored
    always_ff @(posedge core_clk)
    begin
        if (load_en)
        begin
            mem[load_addr] <= load_data;
        end
    end

    // Stretch reset so the link side sees it on recovery clocks
    always_comb
    begin
        if (reset)
        begin
            hold_next = DEV_RST_HOLD_CYC;
        end
        else if (hold_reg != 9'h000)
        begin
            hold_next = hold_reg - 9'h001;
        end
        else
        begin
            hold_next = hold_reg;
        end
    end

    always_ff @(posedge core_clk)
    begin
        hold_reg <= hold_next;
        hold_act_reg <= (hold_next != 9'h000);
    end

    // Bit value of the clock high phase
    always_ff @(posedge link.scl)
    begin
        sda_pos_reg <= link.sda;
    end

    always_ff @(negedge link.scl)
    begin
        rst_meta_reg <= hold_act_reg;
        rst_sync_reg <= rst_meta_reg;
        cs_meta_reg <= {chip_select_bit2, chip_select_bit1, chip_select_bit0};
        cs_sync_reg <= cs_meta_reg;
    end

    assign tx_byte = mem[addr_reg];
    assign link.d_sda_o = 1'b0;
    // Released while reset is stretched
    assign link.d_sda_oe = oe_reg && !hold_act_reg;

    always_comb
    begin
        state_next = state_reg;
        cnt_next = cnt_reg;
        idx_next = idx_reg;
        shift_next = shift_reg;
        hi_next = hi_reg;
        addr_next = addr_reg;
        rw_next = rw_reg;
        oe_next = oe_reg;
        rx_byte = {shift_reg[6:0], sda_pos_reg};
        // Data only moves while clock low, so a fall seen at a falling clock
        // edge is a start; after a stop the last sampled bit is low, so in idle
        // any low at the edge counts. Assumes no other traffic in idle.
        start_seen = !link.sda && (sda_pos_reg || (state_reg == EEPR_DS_IDLE));
        if (rst_sync_reg)
        begin
            state_next = EEPR_DS_IDLE;
            cnt_next = 3'h0;
            idx_next = 2'h0;
            shift_next = 8'h00;
            hi_next = 8'h00;
            addr_next = ADDR_RESET;
            rw_next = 1'b0;
            oe_next = 1'b0;
        end
        else if (start_seen)
        begin
            state_next = EEPR_DS_RX;
            cnt_next = 3'h0;
            idx_next = 2'h0;
            oe_next = 1'b0;
        end
        else
        begin
            case (state_reg)
                EEPR_DS_RX:
                begin
                    shift_next = rx_byte;
                    cnt_next = cnt_reg + 3'h1;
                    if (cnt_reg == LAST_BIT)
                    begin
                        oe_next = 1'b1;
                        state_next = EEPR_DS_RX_ACK;
                        if (idx_reg == 2'h0)
                        begin
                            rw_next = rx_byte[0];
                            if ((rx_byte[7:4] != DEV_PREFIX) || (rx_byte[3:1] != cs_sync_reg))
                            begin
                                oe_next = 1'b0;
                                state_next = EEPR_DS_IDLE;
                            end
                        end
                        else if (idx_reg == 2'h1)
                        begin
                            hi_next = rx_byte;
                        end
                        else if (idx_reg == 2'h2)
                        begin
                            addr_next = {hi_reg[6:0], rx_byte};
                        end
                    end
                end
                EEPR_DS_RX_ACK:
                begin
                    cnt_next = 3'h0;
                    oe_next = 1'b0;
                    if (rw_reg && (idx_reg == 2'h0))
                    begin
                        state_next = EEPR_DS_TX;
                        shift_next = {tx_byte[6:0], 1'b0};
                        oe_next = !tx_byte[7];
                        addr_next = addr_reg + 15'h0001;
                    end
                    else
                    begin
                        state_next = EEPR_DS_RX;
                        idx_next = (idx_reg == 2'h3) ? idx_reg : idx_reg + 2'h1;
                    end
                end
                EEPR_DS_TX:
                begin
                    if (cnt_reg == LAST_BIT)
                    begin
                        oe_next = 1'b0;
                        state_next = EEPR_DS_TX_ACK;
                    end
                    else
                    begin
                        oe_next = !shift_reg[7];
                        shift_next = {shift_reg[6:0], 1'b0};
                        cnt_next = cnt_reg + 3'h1;
                    end
                end
                EEPR_DS_TX_ACK:
                begin
                    cnt_next = 3'h0;
                    if (!sda_pos_reg)
                    begin
                        state_next = EEPR_DS_TX;
                        shift_next = {tx_byte[6:0], 1'b0};
                        oe_next = !tx_byte[7];
                        addr_next = addr_reg + 15'h0001;
                    end
                    else
                    begin
                        oe_next = 1'b0;
                        state_next = EEPR_DS_IDLE;
                    end
                end
                default:
                begin
                    oe_next = 1'b0;
                end
            endcase
        end
    end

    // counter untouched by start and stop
    always_ff @(negedge link.scl)
    begin
        state_reg <= state_next;
        cnt_reg <= cnt_next;
        idx_reg <= idx_next;
        shift_reg <= shift_next;
        hi_reg <= hi_next;
        addr_reg <= addr_next;
        rw_reg <= rw_next;
        oe_reg <= oe_next;
    end

endmodule // eepr_device

// >>> logic/eepr_master.sv
`timescale 1ns/1ps
module eepr_master
(
    eepr_link_if.master link,
    input wire logic core_clk,
    input wire logic reset,
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire logic cmd_random,
    input wire logic [2:0] cmd_chip_sel,
    input wire logic [eepr_pkg::ADDR_W-1:0] cmd_word_addr,
    input wire logic [7:0] cmd_count,
    output logic rd_valid,
    output logic [7:0] rd_data,
    output logic rd_last,
    output logic done,
    output logic nack_err
);
    import eepr_pkg::*;

    logic sda_meta_reg;
    logic sda_sync_reg;

    eepr_mst_state_t state_reg;
    eepr_mst_state_t state_next;
    eepr_step_t step_reg;
    eepr_step_t step_next;
    logic [5:0] qcnt_reg;
    logic [5:0] qcnt_next;
    logic [1:0] q_reg;
    logic [1:0] q_next;
    logic [3:0] bitn_reg;
    logic [3:0] bitn_next;
    logic [7:0] shreg_reg;
    logic [7:0] shreg_next;
    logic [7:0] rdsh_reg;
    logic [7:0] rdsh_next;
    logic [7:0] remain_reg;
    logic [7:0] remain_next;
    logic [2:0] chip_reg;
    logic [2:0] chip_next;
    logic [ADDR_W-1:0] waddr_reg;
    logic [ADDR_W-1:0] waddr_next;
    logic scl_reg;
    logic scl_next;
    logic oe_reg;
    logic oe_next;
    logic rd_valid_reg;
    logic rd_valid_next;
    logic [7:0] rd_data_reg;
    logic [7:0] rd_data_next;
    logic rd_last_reg;
    logic rd_last_next;
    logic done_reg;
    logic done_next;
    logic err_reg;
    logic err_next;

    logic tick;
    logic drive_low;
    logic last_byte;

    function automatic logic [7:0] byte_for(input eepr_step_t s, input logic [2:0] cs,
                                            input logic [ADDR_W-1:0] wa);
        logic [7:0] b;
        b = 8'h00;
        case (s)
            EEPR_ST_ADDR_WR: b = {DEV_PREFIX, cs, 1'b0};
            EEPR_ST_WADDR_HI: b = {1'b0, wa[14:8]};
            EEPR_ST_WADDR_LO: b = wa[7:0];
            EEPR_ST_ADDR_RD: b = {DEV_PREFIX, cs, 1'b1};
            default: b = 8'h00;
        endcase
        return b;
    endfunction

    always_ff @(posedge core_clk)
    begin
        sda_meta_reg <= link.sda;
        sda_sync_reg <= sda_meta_reg;
    end

    assign tick = (qcnt_reg == SCL_QTR_CYC - 6'h01);
    assign last_byte = (remain_reg <= 8'h01);
    assign cmd_ready = (state_reg == EEPR_MS_IDLE);
    assign link.scl = scl_reg;
    assign link.m_sda_o = 1'b0;
    assign link.m_sda_oe = oe_reg;
    assign rd_valid = rd_valid_reg;
    assign rd_data = rd_data_reg;
    assign rd_last = rd_last_reg;
    assign done = done_reg;
    assign nack_err = err_reg;

    always_comb
    begin
        drive_low = 1'b0;
        if (bitn_reg < ACK_BIT)
        begin
            if ((step_reg != EEPR_ST_READ) && (step_reg != EEPR_ST_RECOVER))
            begin
                drive_low = !shreg_reg[7];
            end
        end
        // ack all but the last byte
        else if (step_reg == EEPR_ST_READ)
        begin
            drive_low = !last_byte;
        end
    end

    always_comb
    begin
        state_next = state_reg;
        step_next = step_reg;
        qcnt_next = tick ? 6'h00 : qcnt_reg + 6'h01;
        q_next = tick ? q_reg + 2'h1 : q_reg;
        bitn_next = bitn_reg;
        shreg_next = shreg_reg;
        rdsh_next = rdsh_reg;
        remain_next = remain_reg;
        chip_next = chip_reg;
        waddr_next = waddr_reg;
        rd_valid_next = 1'b0;
        rd_data_next = rd_data_reg;
        rd_last_next = rd_last_reg;
        done_next = 1'b0;
        err_next = err_reg;
        scl_next = 1'b1;
        oe_next = 1'b0;
        case (state_reg)
            EEPR_MS_START:
            begin
                scl_next = (q_reg != 2'h0);
                oe_next = q_reg[1];
            end
            EEPR_MS_BYTE, EEPR_MS_REC:
            begin
                scl_next = q_reg[1];
                oe_next = (q_reg == 2'h0) ? oe_reg : drive_low;
            end
            EEPR_MS_STOP:
            begin
                scl_next = q_reg[1];
                oe_next = (q_reg == 2'h0) ? oe_reg : (q_reg != 2'h3);
            end
            default:
            begin
                scl_next = 1'b1;
                oe_next = 1'b0;
            end
        endcase
        if (reset)
        begin
            state_next = EEPR_MS_REC;
            step_next = EEPR_ST_RECOVER;
            qcnt_next = 6'h00;
            q_next = 2'h0;
            bitn_next = 4'h0;
            shreg_next = 8'h00;
            rdsh_next = 8'h00;
            remain_next = 8'h00;
            chip_next = 3'h0;
            waddr_next = ADDR_RESET;
            rd_data_next = 8'h00;
            rd_last_next = 1'b0;
            err_next = 1'b0;
            scl_next = 1'b1;
            oe_next = 1'b0;
        end
        else if (state_reg == EEPR_MS_IDLE)
        begin
            qcnt_next = 6'h00;
            q_next = 2'h0;
            if (cmd_valid)
            begin
                state_next = EEPR_MS_START;
                step_next = cmd_random ? EEPR_ST_ADDR_WR : EEPR_ST_ADDR_RD;
                chip_next = cmd_chip_sel;
                waddr_next = cmd_word_addr;
                remain_next = (cmd_count == 8'h00) ? 8'h01 : cmd_count;
                err_next = 1'b0;
            end
        end
        else if (tick && (q_reg == 2'h3))
        begin
            case (state_reg)
                EEPR_MS_START:
                begin
                    state_next = EEPR_MS_BYTE;
                    bitn_next = 4'h0;
                    shreg_next = byte_for(step_reg, chip_reg, waddr_reg);
                end
                EEPR_MS_REC:
                begin
                    bitn_next = bitn_reg + 4'h1;
                    if (bitn_reg == ACK_BIT)
                    begin
                        state_next = EEPR_MS_STOP;
                    end
                end
                EEPR_MS_BYTE:
                begin
                    bitn_next = bitn_reg + 4'h1;
                    if (bitn_reg < ACK_BIT)
                    begin
                        shreg_next = {shreg_reg[6:0], 1'b0};
                        rdsh_next = {rdsh_reg[6:0], sda_sync_reg};
                    end
                    else if (step_reg == EEPR_ST_READ)
                    begin
                        rd_valid_next = 1'b1;
                        rd_data_next = rdsh_reg;
                        rd_last_next = last_byte;
                        remain_next = remain_reg - 8'h01;
                        bitn_next = 4'h0;
                        if (last_byte)
                        begin
                            state_next = EEPR_MS_STOP;
                        end
                    end
                    else if (sda_sync_reg)
                    begin
                        err_next = 1'b1;
                        state_next = EEPR_MS_STOP;
                    end
                    else
                    begin
                        bitn_next = 4'h0;
                        case (step_reg)
                            EEPR_ST_ADDR_WR: step_next = EEPR_ST_WADDR_HI;
                            EEPR_ST_WADDR_HI: step_next = EEPR_ST_WADDR_LO;
                            EEPR_ST_WADDR_LO: step_next = EEPR_ST_ADDR_RD;
                            default: step_next = EEPR_ST_READ;
                        endcase
                        shreg_next = byte_for(step_next, chip_reg, waddr_reg);
                        if (step_reg == EEPR_ST_WADDR_LO)
                        begin
                            state_next = EEPR_MS_START;
                        end
                    end
                end
                EEPR_MS_STOP:
                begin
                    state_next = EEPR_MS_IDLE;
                    done_next = (step_reg != EEPR_ST_RECOVER);
                end
                default:
                begin
                    state_next = EEPR_MS_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk)
    begin
        state_reg <= state_next;
        step_reg <= step_next;
        qcnt_reg <= qcnt_next;
        q_reg <= q_next;
        bitn_reg <= bitn_next;
        shreg_reg <= shreg_next;
        rdsh_reg <= rdsh_next;
        remain_reg <= remain_next;
        chip_reg <= chip_next;
        waddr_reg <= waddr_next;
        scl_reg <= scl_next;
        oe_reg <= oe_next;
        rd_valid_reg <= rd_valid_next;
        rd_data_reg <= rd_data_next;
        rd_last_reg <= rd_last_next;
        done_reg <= done_next;
        err_reg <= err_next;
    end

endmodule // eepr_master

// >>> tb/eepr_link_checker.sv
`timescale 1ns/1ps
module eepr_link_checker
(
    input wire logic core_clk,
    input wire logic reset,
    input wire logic scl,
    input wire logic m_sda_o,
    input wire logic m_sda_oe,
    input wire logic d_sda_o,
    input wire logic d_sda_oe,
    input wire logic sda
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (reset);
    property p_dev_fall;
        $fell(d_sda_oe) |-> !scl;
    endproperty
    a_dev_fall: assert property (p_dev_fall)
        else $error("device released data with clock high");
    property p_mst_edge;
        $changed(m_sda_oe) && scl && $past(scl) |-> !d_sda_oe;
    endproperty
    a_mst_edge: assert property (p_mst_edge)
        else $error("master start or stop while device drives");
    property p_dev_rise;
        $rose(d_sda_oe) |-> !scl;
    endproperty
    a_dev_rise: assert property (p_dev_rise)
        else $error("device drove data with clock high");
    property p_dev_hold;
        scl && $past(scl) |-> $stable(d_sda_oe);
    endproperty
    a_dev_hold: assert property (p_dev_hold)
        else $error("device data moved during clock high");
    property p_no_clash;
        $rose(scl) |-> !(m_sda_oe && d_sda_oe);
    endproperty
    a_no_clash: assert property (p_no_clash)
        else $error("both ends drive data at clock rise");
    property p_start;
        $fell(sda) && scl && $past(scl) |-> m_sda_oe && !d_sda_oe;
    endproperty
    a_start: assert property (p_start)
        else $error("start not made by master alone");
    property p_stop_rel;
        $rose(sda) && scl && $past(scl) |=> !d_sda_oe [*8];
    endproperty
    a_stop_rel: assert property (p_stop_rel)
        else $error("device drove data after stop");
    property p_reset_idle;
        disable iff (1'b0) reset |=> scl && !m_sda_oe && !d_sda_oe;
    endproperty
    a_reset_idle: assert property (p_reset_idle)
        else $error("link not idle in reset");
    c_start: cover property ($fell(sda) && scl && $past(scl));
    c_stop: cover property ($rose(sda) && scl && $past(scl));
    c_dev_ack: cover property ($rose(scl) && d_sda_oe);
endmodule // eepr_link_checker

// >>> tb/serial_eeprom_read_ops_tb_top.sv
`timescale 1ns/1ps
module serial_eeprom_read_ops_tb_top;
    import eepr_pkg::*;
    logic core_clk;
    logic reset;
    logic [2:0] strap;
    logic load_en;
    logic [ADDR_W-1:0] load_addr;
    logic [7:0] load_data;
    logic cmd_valid;
    logic cmd_ready;
    logic cmd_random;
    logic [2:0] cmd_chip_sel;
    logic [ADDR_W-1:0] cmd_word_addr;
    logic [7:0] cmd_count;
    logic rd_valid;
    logic [7:0] rd_data;
    logic rd_last;
    logic done;
    logic nack_err;
    logic [7:0] mem [0:MEM_DEPTH-1];
    logic [ADDR_W-1:0] ctr;
    int seed;
    int bad_count = 0;
    int n_tests = 0;
    int cyc = 0;
    int tnum = 0;
    int i;
    eepr_link_if link ();
    eepr_device eepr_device_inst (.link(link), .core_clk(core_clk), .reset(reset),
        .chip_select_bit0(strap[0]), .chip_select_bit1(strap[1]), .chip_select_bit2(strap[2]),
        .load_en(load_en), .load_addr(load_addr), .load_data(load_data));
    eepr_master eepr_master_inst (.link(link), .core_clk(core_clk), .reset(reset),
        .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_random(cmd_random),
        .cmd_chip_sel(cmd_chip_sel), .cmd_word_addr(cmd_word_addr), .cmd_count(cmd_count),
        .rd_valid(rd_valid), .rd_data(rd_data), .rd_last(rd_last), .done(done), .nack_err(nack_err));
    eepr_link_checker eepr_link_checker_inst (.core_clk(core_clk), .reset(reset), .scl(link.scl),
        .m_sda_o(link.m_sda_o), .m_sda_oe(link.m_sda_oe), .d_sda_o(link.d_sda_o),
        .d_sda_oe(link.d_sda_oe), .sda(link.sda));
    initial
    begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end
    function automatic int exp_n(input logic [7:0] c);
        return (c == 8'h00) ? 1 : int'(c);
    endfunction
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        begin
            n_tests++;
            if (got !== exp)
            begin
                bad_count++;
                $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
            end
        end
    endtask
    task automatic conclude();
        begin
            $display("checks %0d mismatches %0d", n_tests, bad_count);
            if (bad_count == 0 && n_tests > 0)
                $display("TEST PASSED");
            else
                $display("TEST FAILED");
            $finish;
        end
    endtask
    task automatic run(input logic rnd, input logic [2:0] cs, input logic [14:0] wa,
        input logic [7:0] cnt, input logic nk);
        int n;
        int w;
        logic [ADDR_W-1:0] a;
        begin
            n = 0;
            w = 0;
            a = rnd ? wa : ctr;
            @(posedge core_clk);
            cmd_valid <= 1'b1;
            cmd_random <= rnd;
            cmd_chip_sel <= cs;
            cmd_word_addr <= wa;
            cmd_count <= cnt;
            @(posedge core_clk);
            while (cmd_ready !== 1'b1)
                @(posedge core_clk);
            cmd_valid <= 1'b0;
            while (done !== 1'b1 && w < 8000)
            begin
                @(posedge core_clk);
                #1;
                w++;
                if (rd_valid === 1'b1)
                begin
                    chk(16'(rd_data), 16'(mem[a]));
                    chk(16'(rd_last), 16'(n + 1 == exp_n(cnt)));
                    a = a + 1'b1;
                    n++;
                end
            end
            chk(16'(nack_err), 16'(nk));
            chk(16'(done), 16'h0001);
            chk(16'(n), nk ? 16'h0000 : 16'(exp_n(cnt)));
            if (!nk)
                ctr = a;
            tnum++;
            $display("test %0d done", tnum);
        end
    endtask
    always @(posedge core_clk)
    begin
        cyc++;
        if (cyc == 75000)
        begin
            bad_count++;
            conclude();
        end
    end
    initial
    begin
        seed = 81530;
        reset = 1'b1;
        strap = 3'h5;
        load_en = 1'b0;
        load_addr = '0;
        load_data = 8'h00;
        cmd_valid = 1'b0;
        cmd_random = 1'b0;
        cmd_chip_sel = 3'h0;
        cmd_word_addr = '0;
        cmd_count = 8'h00;
        ctr = ADDR_RESET;
        repeat (12) @(posedge core_clk);
        reset <= 1'b0;
        for (i = 0; i < MEM_DEPTH; i++)
        begin
            @(posedge core_clk);
            mem[i] = 8'($random(seed));
            load_en <= 1'b1;
            load_addr <= ADDR_W'(i);
            load_data <= mem[i];
        end
        @(posedge core_clk);
        load_en <= 1'b0;
        run(1'b0, 3'h5, 15'h0000, 8'h01, 1'b0);
        run(1'b0, 3'h5, 15'h0000, 8'h00, 1'b0);
        run(1'b1, 3'h5, 15'h7ffe, 8'h04, 1'b0);
        run(1'b1, 3'h2, 15'h1234, 8'h01, 1'b1);
        run(1'b0, 3'h5, 15'h0000, 8'h03, 1'b0);
        for (i = 0; i < 6; i++)
        begin
            @(posedge core_clk);
            strap <= 3'($random(seed));
            repeat (2) @(posedge core_clk);
            run(1'($random(seed)), strap, 15'($random(seed)), 8'({$random(seed)} % 5), 1'b0);
        end
        conclude();
    end
endmodule // serial_eeprom_read_ops_tb_top
